// File: rtl/cms_pkg.sv
// Constants and types for the calibration mode sequencer
//----------------------------------------------------------------------
// Function
// - Missing command reference value falls back to stored default.
// - Stored reference current feeds charge and capacity gain calibration.
// - Stored reference voltage is a whole-pack value for voltage scales.
// - Stored reference temperature calibrates every temperature input without override.
// - Zero-offset duration default 250 ms, truncated to 250 multiples, error below.
// - Converter offset duration default 32 ms, truncated, error below 32.
// - Gain duration default 250 ms, truncated to 250 multiples, error below.
// - Voltage scale duration default 1984 ms, truncated, error below 1984.
// - Each temperature calibration default 32 ms, truncated, error below 32.
// - Session timer starts on entry; expiry returns to normal gauging.
// - Session timeout counts 1/128 s ticks, default 38400 ticks.
// - Converter offset refreshed by every automatic offset run in gauging.
// - Temperature conversion raises converter readings below floor 0 to the floor.
// - Temperature conversion clamps to ceiling 4012 before the second thermistor offset is subtracted.
// - Temperature curve is a fixed four-coefficient polynomial per path.
// - Second thermistor reading has its offset subtracted, no gain correction.
// - Sense inputs are shorted internally during zero-offset calibration.
//----------------------------------------------------------------------
package cms_pkg;

   // -------------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------------
   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned MS_PER_S        = 1000;
   localparam int unsigned CYC_PER_MS      = CLK_HZ / MS_PER_S;
   localparam int unsigned SESSION_TICK_HZ = 128;
   localparam int unsigned CYC_PER_TICK    = CLK_HZ / SESSION_TICK_HZ;

   // -------------------------------------------------------------------
   // Duration granules, defaults and limits
   // -------------------------------------------------------------------
   localparam logic [15:0] ZERO_OFS_MS   = 16'h00fa;  // 250
   localparam logic [15:0] CONV_OFS_MS   = 16'h0020;  // 32
   localparam logic [15:0] GAIN_MS       = 16'h00fa;  // 250
   localparam logic [15:0] VOLT_MS       = 16'h07c0;  // 1984
   localparam logic [15:0] TEMP_MS       = 16'h0020;  // 32
   localparam logic [15:0] SESSION_TICKS = 16'h9600;  // 38400
   localparam logic [11:0] TEMP_MIN_AD   = 12'h000;
   localparam logic [11:0] TEMP_MAX      = 12'hfac;   // 4012

   // Fixed curve coefficients, integer scaled (c1*x^3+c2*x^2+c3*x+c4)>>SH
   localparam logic signed [23:0] EXT_C1 = 24'sh000001;
   localparam logic signed [23:0] EXT_C2 = -24'sh000010;
   localparam logic signed [23:0] EXT_C3 = 24'sh000400;
   localparam logic signed [23:0] EXT_C4 = 24'sh000800;
   localparam logic signed [23:0] INT_C1 = 24'sh000000;
   localparam logic signed [23:0] INT_C2 = 24'sh000008;
   localparam logic signed [23:0] INT_C3 = 24'sh000200;
   localparam logic signed [23:0] INT_C4 = 24'sh000400;
   localparam int unsigned        POLY_SH = 10;

   // -------------------------------------------------------------------
   // Commands and states
   // -------------------------------------------------------------------
   typedef enum logic [2:0] {
      CMD_ZERO_OFS = 3'h0,
      CMD_CONV_OFS = 3'h1,
      CMD_GAIN     = 3'h2,
      CMD_VOLT     = 3'h3,
      CMD_TEMP_INT = 3'h4,
      CMD_TEMP_EX1 = 3'h5,
      CMD_TEMP_EX2 = 3'h6,
      CMD_VPACK    = 3'h7
   } cms_cmd_t;

   typedef enum logic [1:0] {
      ST_GAUGE = 2'b00,
      ST_IDLE  = 2'b01,
      ST_RUN   = 2'b10
   } cms_state_t;

   typedef struct packed {
      logic        valid;
      cms_cmd_t    cmd;
      logic        has_dur;
      logic [15:0] dur_ms;
      logic        has_ref;
      logic [15:0] ref_val;
   } cms_req_t;

   typedef struct packed {
      logic [15:0] zero_ofs_ms;
      logic [15:0] conv_ofs_ms;
      logic [15:0] gain_ms;
      logic [15:0] volt_ms;
      logic [15:0] temp_ms;
      logic [15:0] session_ticks;
      logic [15:0] ref_current;
      logic [15:0] ref_voltage;
      logic [15:0] ref_temp;
   } cms_cfg_t;

   typedef struct packed {
      logic [15:0] charge_gain_factor;
      logic [15:0] capacity_gain_factor;
      logic [15:0] counter_zero_offset;
      logic [15:0] conv_offset;
      logic [15:0] ref_scale;
      logic [15:0] pack_voltage_scale;
      logic [15:0] int_temp_offset;
      logic [15:0] ext1_temp_offset;
      logic [15:0] second_thermistor_offset;
   } cms_coef_t;

endpackage : cms_pkg

// File: rtl/cms_sequencer.sv
// Calibration mode sequencer with temperature conversion
`timescale 1ns/1ps
module cms_sequencer (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic             ce,
   // Mode control
   input  wire logic             cal_enter,
   input  wire logic             cal_exit,
   // Command
   input  wire cms_pkg::cms_req_t req,
   input  wire cms_pkg::cms_cfg_t cfg,
   // Measurement inputs
   input  wire logic signed [15:0] meas_accum,
   input  wire logic             auto_ofs_done,
   input  wire logic [15:0]      auto_ofs_value,
   input  wire logic [11:0]      thermistor_input_one,
   input  wire logic [11:0]      thermistor_input_two,
   input  wire logic [11:0]      int_sensor_ad,
   // Status
   output logic                  cal_mode,
   output logic                  busy,
   output logic                  done,
   output logic                  cal_error,
   output logic                  short_sense,
   output cms_pkg::cms_coef_t    coef,
   output logic [11:0]           temp_ext1,
   output logic [11:0]           temp_ext2,
   output logic [11:0]           temp_int
);

   typedef struct packed {
      cms_pkg::cms_state_t st;
      cms_pkg::cms_cmd_t   cmd;
      logic [15:0]         refv;
      logic [15:0]         ms_left;
      logic [16:0]         sub;
      logic [15:0]         ticks;
      logic [23:0]         tick_sub;
      logic                done;
      logic                err;
      cms_pkg::cms_coef_t  coef;
      logic [11:0]         t_e1;
      logic [11:0]         t_e2;
      logic [11:0]         t_in;
   } cms_state_s_t;

   cms_state_s_t s_q;
   cms_state_s_t s_d;

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function automatic logic [15:0] granule(input cms_pkg::cms_cmd_t c);
      case (c)
         cms_pkg::CMD_ZERO_OFS: granule = cms_pkg::ZERO_OFS_MS;
         cms_pkg::CMD_CONV_OFS: granule = cms_pkg::CONV_OFS_MS;
         cms_pkg::CMD_GAIN:     granule = cms_pkg::GAIN_MS;
         cms_pkg::CMD_VOLT,
         cms_pkg::CMD_VPACK:    granule = cms_pkg::VOLT_MS;
         default:               granule = cms_pkg::TEMP_MS;
      endcase
   endfunction : granule

   function automatic logic [15:0] dflt_dur(input cms_pkg::cms_cmd_t c,
                                            input cms_pkg::cms_cfg_t f);
      case (c)
         cms_pkg::CMD_ZERO_OFS: dflt_dur = f.zero_ofs_ms;
         cms_pkg::CMD_CONV_OFS: dflt_dur = f.conv_ofs_ms;
         cms_pkg::CMD_GAIN:     dflt_dur = f.gain_ms;
         cms_pkg::CMD_VOLT,
         cms_pkg::CMD_VPACK:    dflt_dur = f.volt_ms;
         default:               dflt_dur = f.temp_ms;
      endcase
   endfunction : dflt_dur

   // Polynomial in Horner form, floor and ceiling applied
   function automatic logic [11:0] conv_temp(
      input logic [11:0]        ad,
      input logic signed [23:0] c1,
      input logic signed [23:0] c2,
      input logic signed [23:0] c3,
      input logic signed [23:0] c4);
      logic signed [63:0] x;
      logic signed [63:0] acc;
      x   = 64'(signed'({1'b0, ad}));
      if (ad < cms_pkg::TEMP_MIN_AD)
         x = 64'(signed'({1'b0, cms_pkg::TEMP_MIN_AD}));
      acc = 64'(c1);
      acc = acc * x + 64'(c2);
      acc = acc * x + 64'(c3);
      acc = acc * x + 64'(c4);
      acc = acc >>> cms_pkg::POLY_SH;
      if (acc < 0)
         conv_temp = 12'h000;
      else if (acc > 64'(cms_pkg::TEMP_MAX))
         conv_temp = cms_pkg::TEMP_MAX;
      else
         conv_temp = acc[11:0];
   endfunction : conv_temp

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   logic [15:0] dur;
   logic [15:0] q_dur;
   logic [15:0] e2_raw;

   always_comb begin
      s_d        = s_q;
      s_d.done   = 1'b0;
      dur        = req.has_dur ? req.dur_ms : dflt_dur(req.cmd, cfg);
      // Truncate to a whole number of granules
      q_dur      = 16'((dur / granule(req.cmd)) * granule(req.cmd));

      // Automatic offset refresh in gauging mode
      if (s_q.st == cms_pkg::ST_GAUGE && auto_ofs_done)
         s_d.coef.conv_offset = auto_ofs_value;

      // Session timer ticks in 1/128 s
      if (s_q.st != cms_pkg::ST_GAUGE) begin
         if (s_q.tick_sub == 24'(cms_pkg::CYC_PER_TICK - 1)) begin
            s_d.tick_sub = 24'h000000;
            s_d.ticks    = s_q.ticks + 16'h0001;
         end else begin
            s_d.tick_sub = s_q.tick_sub + 24'h000001;
         end
      end

      case (s_q.st)
         cms_pkg::ST_GAUGE: begin
            if (cal_enter) begin
               s_d.st       = cms_pkg::ST_IDLE;
               s_d.ticks    = 16'h0000;
               s_d.tick_sub = 24'h000000;
               s_d.err      = 1'b0;
            end
         end
         cms_pkg::ST_IDLE: begin
            if (req.valid) begin
               s_d.cmd = req.cmd;
               // Stored default when no value given
               s_d.refv = req.has_ref ? req.ref_val :
                  (req.cmd == cms_pkg::CMD_GAIN) ? cfg.ref_current :
                  (req.cmd == cms_pkg::CMD_VOLT ||
                   req.cmd == cms_pkg::CMD_VPACK) ? cfg.ref_voltage :
                  (req.cmd >= cms_pkg::CMD_TEMP_INT) ? cfg.ref_temp :
                  16'h0000;
               if (dur < granule(req.cmd)) begin
                  s_d.err  = 1'b1;
                  s_d.done = 1'b1;
               end else begin
                  s_d.err     = 1'b0;
                  s_d.ms_left = q_dur;
                  s_d.sub     = 17'h00000;
                  s_d.st      = cms_pkg::ST_RUN;
               end
            end
         end
         cms_pkg::ST_RUN: begin
            // Millisecond counter on the time base
            if (s_q.sub == 17'(cms_pkg::CYC_PER_MS - 1)) begin
               s_d.sub     = 17'h00000;
               s_d.ms_left = s_q.ms_left - 16'h0001;
               if (s_q.ms_left == 16'h0001) begin
                  s_d.st   = cms_pkg::ST_IDLE;
                  s_d.done = 1'b1;
                  case (s_q.cmd)
                     cms_pkg::CMD_ZERO_OFS:
                        s_d.coef.counter_zero_offset = meas_accum;
                     cms_pkg::CMD_CONV_OFS:
                        s_d.coef.conv_offset = meas_accum;
                     cms_pkg::CMD_GAIN: begin
                        s_d.coef.charge_gain_factor   = s_q.refv;
                        s_d.coef.capacity_gain_factor = s_q.refv;
                     end
                     cms_pkg::CMD_VOLT:
                        s_d.coef.ref_scale = s_q.refv;
                     cms_pkg::CMD_VPACK:
                        s_d.coef.pack_voltage_scale = s_q.refv;
                     cms_pkg::CMD_TEMP_INT:
                        s_d.coef.int_temp_offset =
                           16'(s_q.t_in) - s_q.refv;
                     cms_pkg::CMD_TEMP_EX1:
                        s_d.coef.ext1_temp_offset =
                           16'(s_q.t_e1) - s_q.refv;
                     cms_pkg::CMD_TEMP_EX2:
                        s_d.coef.second_thermistor_offset =
                           16'(conv_temp(thermistor_input_two,
                              cms_pkg::EXT_C1, cms_pkg::EXT_C2,
                              cms_pkg::EXT_C3, cms_pkg::EXT_C4))
                           - s_q.refv;
                     default: ;
                  endcase
               end
            end else begin
               s_d.sub = s_q.sub + 17'h00001;
            end
         end
         default: s_d.st = cms_pkg::ST_GAUGE;
      endcase

      // Timeout or exit returns to gauging
      if (s_q.st != cms_pkg::ST_GAUGE &&
          (cal_exit || s_q.ticks >= cfg.session_ticks))
         s_d.st = cms_pkg::ST_GAUGE;

      // Temperature reporting
      s_d.t_e1 = conv_temp(thermistor_input_one, cms_pkg::EXT_C1,
         cms_pkg::EXT_C2, cms_pkg::EXT_C3, cms_pkg::EXT_C4);
      s_d.t_in = conv_temp(int_sensor_ad, cms_pkg::INT_C1,
         cms_pkg::INT_C2, cms_pkg::INT_C3, cms_pkg::INT_C4);
      e2_raw = 16'(conv_temp(thermistor_input_two, cms_pkg::EXT_C1,
         cms_pkg::EXT_C2, cms_pkg::EXT_C3, cms_pkg::EXT_C4));
      s_d.t_e2 = 12'(e2_raw - s_q.coef.second_thermistor_offset);
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         s_q    <= '0;
         s_q.st <= cms_pkg::ST_GAUGE;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign cal_mode  = (s_q.st != cms_pkg::ST_GAUGE);
   assign busy      = (s_q.st == cms_pkg::ST_RUN);
   assign done      = s_q.done;
   assign cal_error = s_q.err;
   // Short sense inputs during zero-offset run
   assign short_sense = busy && (s_q.cmd == cms_pkg::CMD_ZERO_OFS);
   assign coef      = s_q.coef;
   assign temp_ext1 = s_q.t_e1;
   assign temp_ext2 = s_q.t_e2;
   assign temp_int  = s_q.t_in;

endmodule : cms_sequencer

// File: dv/cms_assertions.sv
// Concurrent checks on the calibration mode sequencer ports
`timescale 1ns/1ps
module cms_assertions (
   // Clock and reset
   input wire logic               clk,
   input wire logic               nrst,
   input wire logic               ce,
   // Controls
   input wire logic               cal_enter,
   input wire cms_pkg::cms_req_t  req,
   input wire cms_pkg::cms_cfg_t  cfg,
   input wire logic               auto_ofs_done,
   input wire logic [15:0]        auto_ofs_value,
   // Status
   input wire logic               cal_mode,
   input wire logic               busy,
   input wire logic               done,
   input wire logic               cal_error,
   input wire logic               short_sense,
   input wire cms_pkg::cms_coef_t coef,
   input wire logic [11:0]        temp_ext1,
   input wire logic [11:0]        temp_ext2,
   input wire logic [11:0]        temp_int
);
   logic [15:0] dur;
   logic [15:0] grain;
   logic        take;
   logic        bad;

   always_comb begin
      case (req.cmd)
         cms_pkg::CMD_ZERO_OFS: {grain, dur} = {16'h00fa, cfg.zero_ofs_ms};
         cms_pkg::CMD_CONV_OFS: {grain, dur} = {16'h0020, cfg.conv_ofs_ms};
         cms_pkg::CMD_GAIN:     {grain, dur} = {16'h00fa, cfg.gain_ms};
         cms_pkg::CMD_VOLT,
         cms_pkg::CMD_VPACK:    {grain, dur} = {16'h07c0, cfg.volt_ms};
         default:               {grain, dur} = {16'h0020, cfg.temp_ms};
      endcase
      if (req.has_dur) begin
         dur = req.dur_ms;
      end
   end
   assign take = ce && req.valid && cal_mode && !busy;
   assign bad  = dur < grain;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence s_take_bad;
      take && bad;
   endsequence
   sequence s_err_answer;
      done && cal_error && !busy;
   endsequence

   chk_err_answer: assert property (s_take_bad |=> s_err_answer)
      else $error("short duration not answered with error");
   chk_err_keeps: assert property (s_take_bad |=> $stable(coef))
      else $error("coefficients changed on error");
   chk_ok_starts: assert property (take && !bad |=> busy && !cal_error && !done)
      else $error("valid command did not start");
   chk_zero_short: assert property (take && !bad &&
         req.cmd == cms_pkg::CMD_ZERO_OFS |=> short_sense)
      else $error("sense inputs not shorted");
   chk_short_busy: assert property (short_sense |-> busy && cal_mode)
      else $error("short outside a run");
   chk_done_pulse: assert property (done |=> !done)
      else $error("done longer than one cycle");
   chk_gauge_idle: assert property (!cal_mode && req.valid |=> !busy)
      else $error("command taken in gauging");
   chk_enter_mode: assert property (ce && cal_enter && !cal_mode |=> cal_mode)
      else $error("entry not taken");
   chk_auto_ofs: assert property (ce && auto_ofs_done && !cal_mode &&
         !cal_enter |=> coef.conv_offset == $past(auto_ofs_value))
      else $error("automatic offset not loaded");
   chk_temp_ceil: assert property (temp_int <= 12'hfac &&
         temp_ext1 <= 12'hfac && temp_ext2 <= 12'hfac)
      else $error("temperature above ceiling");
endmodule : cms_assertions

bind cms_sequencer cms_assertions u_cms_assertions (.clk(clk), .nrst(nrst),
   .ce(ce), .cal_enter(cal_enter), .req(req), .cfg(cfg),
   .auto_ofs_done(auto_ofs_done), .auto_ofs_value(auto_ofs_value),
   .cal_mode(cal_mode), .busy(busy), .done(done), .cal_error(cal_error),
   .short_sense(short_sense), .coef(coef), .temp_ext1(temp_ext1),
   .temp_ext2(temp_ext2), .temp_int(temp_int));

// File: dv/cms_host.sv
// Host model issuing calibration commands
`timescale 1ns/1ps
module cms_host (
   // Clock
   input  wire logic       clk,
   // Command
   output cms_pkg::cms_req_t req
);
   initial req = '0;
   // Idle fields keep moving so stale values never pass as held
   always @(negedge clk) begin
      if (!req.valid) begin
         req.dur_ms  <= ~req.dur_ms;
         req.ref_val <= ~req.ref_val;
      end
   end

   task automatic send(input cms_pkg::cms_cmd_t c, input logic hd,
                       input logic [15:0] d);
      @(posedge clk);
      req <= '{1'b1, c, hd, d, 1'b0, 16'h0000};
      @(posedge clk);
      req.valid <= 1'b0;
      #1;
   endtask : send
endmodule : cms_host

// File: dv/tb.sv
// Self-checking bench for the calibration mode sequencer
`timescale 1ns/1ps
module tb;
   logic                clk = 1'b0;
   logic                nrst = 1'b0;
   logic                ce = 1'b1;
   logic                cal_enter = 1'b0;
   logic                cal_exit = 1'b0;
   logic                ao_done = 1'b0;
   logic [15:0]         ao_val = 16'h0000;
   logic [31:0]         rng = 32'hbc7b;
   cms_pkg::cms_cfg_t   cfg;
   cms_pkg::cms_req_t   req;
   cms_pkg::cms_coef_t  coef;
   cms_pkg::cms_coef_t  snap;
   logic                cal_mode, busy, done, cal_error, short_sense;
   logic [11:0]         t1, t2, ti;
   logic [15:0]         v;
   logic [2:0]          e;
   int                  d;
   int                  num_errors = 0;
   int                  n_tests = 0;
   int                  grain_tab[8] = '{250, 32, 250, 1984, 32, 32, 32, 1984};
   logic [35:0]         px;
   logic [15:0]         po;
   logic                t_ok = 1'b0;

   always #5 clk = ~clk;

   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   always @(posedge clk) begin
      rng <= xs(rng);
   end

   cms_host u_cms_host (.clk(clk), .req(req));
   cms_sequencer u_cms_sequencer (.clk(clk), .nrst(nrst), .ce(ce),
      .cal_enter(cal_enter), .cal_exit(cal_exit), .req(req), .cfg(cfg),
      .meas_accum(rng[31:16]), .auto_ofs_done(ao_done),
      .auto_ofs_value(ao_val), .thermistor_input_one(rng[11:0]),
      .thermistor_input_two(rng[23:12]), .int_sensor_ad(rng[31:20]),
      .cal_mode(cal_mode), .busy(busy), .done(done), .cal_error(cal_error),
      .short_sense(short_sense), .coef(coef), .temp_ext1(t1),
      .temp_ext2(t2), .temp_int(ti));

   task automatic check(input string nm, input logic [159:0] seen,
                        input logic [159:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   // Curve model: fixed coefficients, floor and ceiling
   function automatic logic [11:0] tmodel(input logic [11:0] a,
                                          input logic ext);
      longint c[4];
      longint x;
      longint acc;
      if (ext) begin
         c = '{longint'(cms_pkg::EXT_C1), longint'(cms_pkg::EXT_C2),
               longint'(cms_pkg::EXT_C3), longint'(cms_pkg::EXT_C4)};
      end else begin
         c = '{longint'(cms_pkg::INT_C1), longint'(cms_pkg::INT_C2),
               longint'(cms_pkg::INT_C3), longint'(cms_pkg::INT_C4)};
      end
      x = longint'(a);
      acc = ((c[0] * x + c[1]) * x + c[2]) * x + c[3];
      acc = acc >>> cms_pkg::POLY_SH;
      if (acc < 0) return 12'h000;
      if (acc > longint'(cms_pkg::TEMP_MAX)) return cms_pkg::TEMP_MAX;
      return 12'(acc);
   endfunction : tmodel

   // Outputs lag one enabled edge behind the readings
   always @(posedge clk) begin
      if (t_ok) begin
         check("temp_ext1", t1, tmodel(px[11:0], 1'b1));
         check("temp_int", ti, tmodel(px[35:24], 1'b0));
         check("temp_ext2", t2,
            12'(16'(tmodel(px[23:12], 1'b1)) - po));
      end
      t_ok <= nrst && ce;
      px   <= {rng[31:20], rng[23:12], rng[11:0]};
      po   <= coef.second_thermistor_offset;
   end

   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : results

   // Stored durations at the granule, or one below it
   task automatic load_cfg(input logic [15:0] k);
      cfg <= '{16'h00fa - k, 16'h0020 - k, 16'h00fa - k, 16'h07c0 - k,
               16'h0020 - k, cms_pkg::SESSION_TICKS, 16'h0bb8, 16'h3a98,
               16'h0bb8};
   endtask : load_cfg

   task automatic mode(input logic in);
      @(posedge clk);
      if (in) cal_enter <= 1'b1;
      else cal_exit <= 1'b1;
      @(posedge clk);
      {cal_enter, cal_exit} <= 2'b00;
      #1;
      check("mode", {cal_mode, busy, cal_error}, {in, 2'b00});
   endtask : mode

   initial begin
      #200_000;
      num_errors++;
      results();
   end

   initial begin
      load_cfg(16'h0000);
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      #1;
      check("reset", {cal_mode, busy, done, cal_error, coef}, '0);
      u_cms_host.send(cms_pkg::CMD_GAIN, 1'b1, 16'h01f4);
      check("refused", {busy, done}, 2'b00);
      // Enable low must freeze the offset load
      ce <= 1'b0;
      ao_val <= 16'hffff;
      ao_done <= 1'b1;
      @(posedge clk);
      #1;
      check("frozen", coef.conv_offset, 16'h0000);
      ce <= 1'b1;
      v = rng[15:0];
      ao_val <= v;
      ao_done <= 1'b1;
      @(posedge clk);
      ao_done <= 1'b0;
      #1;
      check("conv_offset", coef.conv_offset, v);
      mode(1'b1);
      // Second pass leaves the duration to the stored defaults
      for (int p = 0; p < 2; p++) begin
         load_cfg(16'(p));
         for (int c = 0; c < 8; c++) begin
            snap = coef;
            d = (p == 0) ? grain_tab[c] - 1 : grain_tab[c] - p;
            e = (d < grain_tab[c]) ? 3'b110 : 3'b001;
            u_cms_host.send(cms_pkg::cms_cmd_t'(c), p == 0, 16'(d));
            check("err", {done, cal_error, busy}, e);
            check("keep", coef, snap);
         end
      end
      load_cfg(16'h0000);
      for (int c = 0; c < 8; c++) begin
         // Host picks a longer gain run
         d = (c == 2) ? 500 : 2 * grain_tab[c] - 1;
         u_cms_host.send(cms_pkg::cms_cmd_t'(c), c != 4, 16'(d));
         check("run", {busy, done, cal_error, short_sense}, {3'b100, c == 0});
         mode(1'b0);
         mode(1'b1);
      end
      results();
   end
endmodule : tb
